// [core/dcas_consts.vh]
`ifndef DCAS_CONSTS_VH
`define DCAS_CONSTS_VH
// Status field positions inside the debug control word
`define DCAS_SIZE_HI       30
`define DCAS_SIZE_LO       29
`define DCAS_LOWPWR_BIT    22
`define DCAS_HALT_BIT      21
`define DCAS_PEND_BIT      18
// Size codes
`define DCAS_SZ_BYTE       2'h0
`define DCAS_SZ_HALF       2'h1
`define DCAS_SZ_WORD       2'h2
`define DCAS_SZ_TRIPLE     2'h3
// Reset values of the status flags
`define DCAS_LOWPWR_RST    1'h0
`define DCAS_HALT_RST      1'h0
// Test access port state codes for capture, shift and update
`define DCAS_TAP_CAPTURE   4'h6
`define DCAS_TAP_SHIFT     4'h2
`define DCAS_TAP_UPDATE    4'h5
// Width of the control word
`define DCAS_WORD_W        32
`endif

// [core/dcas_lane_dec.v]
`timescale 1ns/1ps
`default_nettype none
`include "dcas_consts.vh"
// Decodes size code and low address bits into byte lanes
module dcas_lane_dec (
  input  wire [1:0] size_code,   // Transfer size code
  input  wire [1:0] addr_low,    // Low two address bits
  input  wire       big_endian,  // Endianness of the core
  output reg  [3:0] lanes,       // Byte lane enables, bit n = byte n
  output reg        reserved     // Combination not defined
);
  // Lane numbers are fixed in the word; only the selection moves
  always @* begin
    lanes    = 4'h0;
    reserved = 1'b0;
    case (size_code)
      `DCAS_SZ_BYTE: begin
        // One lane per address; big endian mirrors the index
        if (big_endian)
          lanes = 4'h8 >> addr_low; // RULE3
        else
          lanes = 4'h1 << addr_low; // RULE3
      end
      `DCAS_SZ_HALF: begin
        if (addr_low == 2'h0)
          lanes = big_endian ? 4'hC : 4'h3; // RULE4
        else if (addr_low == 2'h2)
          lanes = big_endian ? 4'h3 : 4'hC; // RULE4
        else
          reserved = 1'b1;
      end
      `DCAS_SZ_WORD: begin
        if (addr_low == 2'h0)
          lanes = 4'hF; // RULE5
        else
          reserved = 1'b1;
      end
      `DCAS_SZ_TRIPLE: begin
        if (addr_low == 2'h0)
          lanes = big_endian ? 4'hE : 4'h7; // RULE6
        else if (addr_low == 2'h1)
          lanes = big_endian ? 4'h7 : 4'hE; // RULE6
        else
          reserved = 1'b1;
      end
      default: begin
        reserved = 1'b1;
      end
    endcase
  end
endmodule // dcas_lane_dec
`default_nettype wire

// [core/dcas_status.v]
// Notes on behaviour
// RULE1: Size code read-only at bits 30:29.
// RULE2: Probe trusts size only while access pending.
// RULE3: Size 00 is one byte by address.
// RULE4: Size 01 is halfword at address 00/10.
// RULE5: Size 10 at address 00 is word.
// RULE6: Size 11 is triple at address 00/01.
// RULE7: Other combinations are reserved for the probe.
// RULE8: Byte lanes fixed in word, any endianness.
// RULE9: Bit 22 reads low-power state, reset 0.
// RULE10: Low-power flag sampled at capture state.
// RULE11: Low-power covers reduced power and wait.
// RULE12: Bit 21 reads bus clock stopped, reset 0.
// RULE13: Halt flag sampled at capture state.
// RULE14: Bit 18 shows pending processor access.
// RULE15: Register reachable only by test port path.
`timescale 1ns/1ps
`default_nettype none
`include "dcas_consts.vh"
module dcas_status #(
  parameter WORD_W = `DCAS_WORD_W  // Shift register length
) (
  input  wire        mclk,             // System clock, 50 MHz
  input  wire        rst_n,            // Synchronous reset, low active
  input  wire        clk_en,           // Freezes all state while low
  input  wire        tck,              // Test clock pin, sampled
  input  wire        tdi,              // Test data in pin
  input  wire [3:0]  tap_state,        // Test controller state, TCK domain
  input  wire        sel_ctrl,         // Control register selected
  input  wire        pending_access_flag, // Processor access waiting
  input  wire [1:0]  processor_access_size, // Size of the pending access
  input  wire [1:0]  access_addr_low,  // Low address bits of access
  input  wire        big_endian,       // Core endianness
  input  wire        reduced_power,    // CPU in reduced power mode
  input  wire        wait_mode,        // CPU stopped by wait instruction
  input  wire        bus_clk_stopped,  // Internal bus clock stopped
  output reg         tdo_r,            // Test data out
  output reg  [3:0]  lanes_r,          // Decoded byte lanes
  output reg         lanes_reserved_r, // Size/address pair undefined
  output reg         lowpwr_r,         // Captured low-power flag
  output reg         halt_r            // Captured halt flag
);
  // Two-stage synchronisers; stage one feeds only stage two
  reg        tck_s1_r;      // TCK first stage
  reg        tck_s2_r;      // TCK second stage
  reg        tck_d_r;       // TCK delayed for edge detection
  reg        tdi_s1_r;      // TDI first stage
  reg        tdi_s2_r;      // TDI second stage
  reg  [3:0] st_s1_r;       // TAP state first stage
  reg  [3:0] st_s2_r;       // TAP state second stage
  reg        sel_s1_r;      // Select first stage
  reg        sel_s2_r;      // Select second stage
  reg  [1:0] lp_s1_r;       // Wait and reduced power, first stage
  reg  [1:0] lp_s2_r;       // Wait and reduced power, second stage
  reg        hl_s1_r;       // Halt first stage
  reg        hl_s2_r;       // Halt second stage
  reg [WORD_W-1:0] shift_r; // Data register shift path
  wire       tck_rise;      // Rising TCK seen
  wire       tck_fall;      // Falling TCK seen
  wire [3:0] dec_lanes;     // Decoder lanes
  wire       dec_res;       // Decoder reserved flag
  wire       lp_any;        // Either low-power mode

  // Doze covers both kinds of low power; merged only after the
  // synchronisers so no gate ever sees a raw CPU-domain level
  assign lp_any = |lp_s2_r; // RULE11

  // Synchronise the test pins and the low-power and halt inputs; access size, address and pending flag are used unsynchronised
  always @(posedge mclk) begin
    if (!rst_n) begin
      tck_s1_r <= 1'b0;
      tck_s2_r <= 1'b0;
      tck_d_r  <= 1'b0;
      tdi_s1_r <= 1'b0;
      tdi_s2_r <= 1'b0;
      st_s1_r  <= 4'h0;
      st_s2_r  <= 4'h0;
      sel_s1_r <= 1'b0;
      sel_s2_r <= 1'b0;
      lp_s1_r  <= 2'h0;
      lp_s2_r  <= 2'h0;
      hl_s1_r  <= 1'b0;
      hl_s2_r  <= 1'b0;
    end else if (clk_en) begin
      tck_s1_r <= tck;
      tck_s2_r <= tck_s1_r;
      tck_d_r  <= tck_s2_r;
      tdi_s1_r <= tdi;
      tdi_s2_r <= tdi_s1_r;
      st_s1_r  <= tap_state;
      st_s2_r  <= st_s1_r;
      sel_s1_r <= sel_ctrl;
      sel_s2_r <= sel_s1_r;
      lp_s1_r  <= {wait_mode, reduced_power};
      lp_s2_r  <= lp_s1_r;
      hl_s1_r  <= bus_clk_stopped;
      hl_s2_r  <= hl_s1_r;
    end
  end

  assign tck_rise = tck_s2_r & ~tck_d_r;
  assign tck_fall = ~tck_s2_r & tck_d_r;

  // Lane decoder for the pending access
  dcas_lane_dec u_dec (
    .size_code  (processor_access_size),
    .addr_low   (access_addr_low),
    .big_endian (big_endian),
    .lanes      (dec_lanes),
    .reserved   (dec_res)
  );

  // Lanes only mean something while an access waits
  always @(posedge mclk) begin
    if (!rst_n) begin
      lanes_r          <= 4'h0;
      lanes_reserved_r <= 1'b0;
    end else if (clk_en) begin
      if (pending_access_flag) begin // RULE2
        lanes_r          <= dec_lanes; // RULE8
        lanes_reserved_r <= dec_res;   // RULE7
      end else begin
        lanes_r          <= 4'h0;
        lanes_reserved_r <= 1'b0;
      end
    end
  end

  // Shift path: capture on TCK rise in Capture-DR, shift in Shift-DR, hold otherwise.
  // Only the test port reaches it; no CPU write path exists.
  always @(posedge mclk) begin
    if (!rst_n) begin
      shift_r  <= {WORD_W{1'b0}};
      lowpwr_r <= `DCAS_LOWPWR_RST; // RULE9
      halt_r   <= `DCAS_HALT_RST;   // RULE12
    end else if (clk_en && tck_rise && sel_s2_r) begin // RULE15
      if (st_s2_r == `DCAS_TAP_CAPTURE) begin
        shift_r <= {WORD_W{1'b0}};
        shift_r[`DCAS_SIZE_HI:`DCAS_SIZE_LO] <= processor_access_size; // RULE1
        shift_r[`DCAS_LOWPWR_BIT] <= lp_any; // RULE10
        shift_r[`DCAS_HALT_BIT]   <= hl_s2_r; // RULE13
        shift_r[`DCAS_PEND_BIT]   <= pending_access_flag; // RULE14
        lowpwr_r <= lp_any; // RULE9
        halt_r   <= hl_s2_r; // RULE12
      end else if (st_s2_r == `DCAS_TAP_SHIFT) begin
        shift_r <= {tdi_s2_r, shift_r[WORD_W-1:1]};
      end
    end
  end

  // TDO changes on falling TCK, as the probe samples on rise
  always @(posedge mclk) begin
    if (!rst_n) begin
      tdo_r <= 1'b0;
    end else if (clk_en && tck_fall) begin
      tdo_r <= shift_r[0];
    end
  end
endmodule // dcas_status
`default_nettype wire

// [testbench/dcas_probe.sv]
`timescale 1ns/1ps
`default_nettype none
// Probe model; tck rests low between frames
module dcas_probe (
  input  wire logic       tdo,
  output var  logic       tck,
  output var  logic       tdi,
  output var  logic [3:0] tap_state
);
  initial {tck, tdi, tap_state} = 6'h00;
  // Capture, then 32 shifts; long low half leaves room for the sync delay
  task automatic scan(output logic [31:0] w);
    tap_state = 4'h6;
    #100 tck = 1;
    #60 tck = 0;
    #50 tap_state = 4'h2;
    #50;
    for (int i = 0; i < 32; i++) begin
      w[i] = tdo;
      tdi = ~tdo;
      tck = 1;
      #60 tck = 0;
      #100;
    end
    tap_state = 4'h0;
  endtask
endmodule // dcas_probe
`default_nettype wire

// [testbench/dcas_status_checker.sv]
`timescale 1ns/1ps
`default_nettype none
// Pin-level checks of the status block
module dcas_status_checker (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       clk_en,
  input wire logic [3:0] tap_state,
  input wire logic       sel_ctrl,
  input wire logic       pending_access_flag,
  input wire logic [1:0] processor_access_size,
  input wire logic [1:0] access_addr_low,
  input wire logic       big_endian,
  input wire logic       tdo_r,
  input wire logic [3:0] lanes_r,
  input wire logic       lanes_reserved_r,
  input wire logic       lowpwr_r,
  input wire logic       halt_r
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // Short names for the access qualifiers
  wire logic       go = pending_access_flag && clk_en;
  wire logic [1:0] sz = processor_access_size;
  wire logic [1:0] ad = access_addr_low;
  a_idle_lanes: assert property (clk_en && !pending_access_flag
    |=> lanes_r == 4'h0) else $error("lanes without access");
  a_byte_lanes: assert property (go && sz == 2'h0
    |=> $countones(lanes_r) == 1) else $error("byte lanes wrong");
  a_half_lanes: assert property (go && sz == 2'h1 && !ad[0]
    |=> $countones(lanes_r) == 2) else $error("half lanes wrong");
  a_word_lanes: assert property (go && sz == 2'h2 && ad == 2'h0
    |=> lanes_r == 4'hF) else $error("word lanes wrong");
  a_three_lanes: assert property (go && sz == 2'h3 && !ad[1]
    |=> $countones(lanes_r) == 3) else $error("triple lanes wrong");
  // Flags may only move shortly after a capture state
  a_flag_capture: assert property ((tap_state != 4'h6)[*8]
    |-> $stable(lowpwr_r) && $stable(halt_r)) else $error("flag moved");
  a_tdo_hold: assert property ((!sel_ctrl)[*8] |-> $stable(tdo_r))
    else $error("tdo moved unselected");
  a_reset_zero: assert property (disable iff (1'b0)
    !rst_n && clk_en |=> !lowpwr_r && !halt_r && lanes_r == 4'h0)
    else $error("reset values wrong");
  c_scan: cover property (tap_state == 4'h6 && sel_ctrl);
  c_res: cover property (lanes_reserved_r);
  c_flags: cover property (lowpwr_r && halt_r);
endmodule // dcas_status_checker
bind dcas_status dcas_status_checker i_chk (.mclk, .rst_n, .clk_en,
  .tap_state, .sel_ctrl, .pending_access_flag, .processor_access_size,
  .access_addr_low, .big_endian, .tdo_r, .lanes_r, .lanes_reserved_r,
  .lowpwr_r, .halt_r);
`default_nettype wire

// [testbench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic mclk = 0, rst_n = 0, clk_en = 1, sel_ctrl = 0, big_endian = 0;
  logic pnd = 0, red_pwr = 0, wt_mode = 0, clk_stop = 0, lp, tck, tdi;
  logic tdo_r, lanes_reserved_r, lowpwr_r, halt_r;
  logic [1:0] sz = 0, ad = 0;
  logic [3:0] tap_state, lanes_r, lh;
  logic [5:0] r, e;
  logic [33:0] qs[$];
  logic [5:0] q[$];
  logic [31:0] w;
  integer seed = 30, err_total = 0, n_tests = 0, cyc = 0, i;
  event got;
  always #10 mclk = ~mclk;
  dcas_status i_dcas_status (.mclk, .rst_n, .clk_en, .tck, .tdi,
    .tap_state, .sel_ctrl, .pending_access_flag(pnd),
    .processor_access_size(sz), .access_addr_low(ad), .big_endian,
    .reduced_power(red_pwr), .wait_mode(wt_mode),
    .bus_clk_stopped(clk_stop), .tdo_r, .lanes_r, .lanes_reserved_r,
    .lowpwr_r, .halt_r);
  dcas_probe i_dcas_probe (.tdo(tdo_r), .tck, .tdi, .tap_state);
  task check(input string nm, input logic [33:0] s, x);
    n_tests++;
    if (s !== x) begin
      err_total++;
      $display("[FAIL] %s exp %h seen %h", nm, x, s);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Expected lanes, bit 4 marks an undefined pair
  function logic [4:0] lanes_exp(input logic [1:0] s, a, input logic b);
    logic [3:0] l;
    case ({s, a})
      4'h0, 4'h1, 4'h2, 4'h3: l = 4'h1 << a;
      4'h4: l = 4'h3;
      4'h6: l = 4'hC;
      4'h8: l = 4'hF;
      4'hC: l = 4'h7;
      4'hD: l = 4'hE;
      default: return 5'h10;
    endcase
    return b ? {1'b0, l[0], l[1], l[2], l[3]} : {1'b0, l};
  endfunction
  // Takes the oldest lane note once the registered lanes settle
  always @(negedge mclk) if (q.size() > 0) begin
    e = q.pop_front();
    if (e[5]) check("idle lanes", lanes_r, 4'h0);
    else if (e[4]) check("reserved", lanes_reserved_r, 1'b1);
    else check("lanes", {lanes_reserved_r, lanes_r}, e[4:0]);
  end
  always @(got) check("word", {lowpwr_r, halt_r, w}, qs.pop_front());
  always @(posedge mclk) if (++cyc == 8000) begin
    err_total++;
    stop_test;
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1;
    // All size and address pairs in both byte orders, then random ones
    for (i = 0; i < 64; i++) begin
      r = (i < 32) ? 6'(i) : 6'($random(seed));
      @(posedge mclk);
      pnd <= r[5] | (i < 32);
      {big_endian, ad, sz} <= r[4:0];
      @(posedge mclk);
      q.push_back({~pnd, lanes_exp(sz, ad, big_endian)});
    end
    $display("test lanes done");
    // Clock enable low must freeze the lane register
    @(posedge mclk);
    clk_en <= 0;
    @(posedge mclk);
    lh = lanes_r;
    pnd <= 1;
    {big_endian, ad, sz} <= 5'h08;
    repeat (3) @(posedge mclk);
    check("frozen lanes", lanes_r, lh);
    clk_en <= 1;
    $display("test freeze done");
    // Power, wait and halt combinations, then random status words
    for (i = 0; i < 12; i++) begin
      r = (i < 8) ? 6'(i) : 6'($random(seed));
      @(posedge mclk);
      {sz, pnd, clk_stop, wt_mode, red_pwr} <= r;
      sel_ctrl <= 1;
      repeat (4) @(posedge mclk);
      lp = r[0] | r[1];
      qs.push_back({lp, r[2], 1'b0, r[5:4], 6'h00, lp, r[2], 2'h0, r[3],
        18'h00000});
      i_dcas_probe.scan(w);
      -> got;
    end
    $display("test scan done");
    repeat (4) @(posedge mclk);
    stop_test;
  end
endmodule // testbench
`default_nettype wire
